// >>> src/uil_pkg.sv
// Package with register map, field positions, reset values and carrier types of the UART block.
package uil_pkg;

   // ****************************************************************
   // Register byte offsets on the AXI4-Lite bus.
   // ****************************************************************
   localparam logic [7:0] UIL_OFS_IDENT = 8'h00; // Interrupt identification, read only.
   localparam logic [7:0] UIL_OFS_LFC = 8'h04; // Line format control.
   localparam logic [7:0] UIL_OFS_FSC = 8'h08; // FIFO setup control.
   localparam logic [7:0] UIL_OFS_DIV = 8'h0C; // Baud divisor latch, gated by the latch bit.
   localparam logic [7:0] UIL_OFS_STAT = 8'h10; // Sticky event status, write one to clear.
   localparam logic [7:0] UIL_OFS_MASK = 8'h14; // Event mask for the interrupt output.

   // ****************************************************************
   // Field positions and widths.
   // ****************************************************************
   localparam int UIL_LFC_DLAB = 7; // Divisor latch access.
   localparam int UIL_LFC_BRK = 6; // Forced break.
   localparam int UIL_LFC_PSTICK = 5; // Parity stick select.
   localparam int UIL_LFC_PEVEN = 4; // Parity even select.
   localparam int UIL_LFC_PEN = 3; // Parity enable.
   localparam int UIL_LFC_STOP = 2; // Long stop select.
   localparam int UIL_FSC_EN = 0; // FIFO enable.
   localparam int UIL_NSRC = 5; // Number of interrupt sources.

   // ****************************************************************
   // Identification codes and reset values.
   // ****************************************************************
   localparam logic [3:0] UIL_ID_LINE = 4'h6; // Receiver line condition.
   localparam logic [3:0] UIL_ID_RXAV = 4'h4; // Receive data available.
   localparam logic [3:0] UIL_ID_TMO = 4'hC; // Receive data time-out.
   localparam logic [3:0] UIL_ID_THRE = 4'h2; // Transmit holding empty.
   localparam logic [3:0] UIL_ID_MODEM = 4'h0; // Modem line change.
   localparam logic [3:0] UIL_ID_NONE = 4'h1; // Nothing pending.
   localparam logic [7:0] UIL_RST_IDENT = 8'h01; // Identification after reset.
   localparam logic [7:0] UIL_RST_LFC = 8'h00; // Line format after reset.
   localparam logic [7:0] UIL_RST_FSC = 8'h00; // FIFO setup after reset.
   localparam logic [15:0] UIL_RST_DIV = 16'h0001; // Divisor after reset.
   localparam logic [1:0] UIL_RESP_OKAY = 2'b00; // AXI okay answer.
   localparam logic [1:0] UIL_RESP_SLVERR = 2'b10; // AXI error answer for unmapped offsets.

   // ****************************************************************
   // Types.
   // ****************************************************************
   typedef enum logic [2:0] {
      UIL_PAR_NONE,
      UIL_PAR_ODD,
      UIL_PAR_EVEN,
      UIL_PAR_ONE,
      UIL_PAR_ZERO
   } uil_par_t;

   // Pending interrupt sources, levels held by the other parts of the UART.
   typedef struct packed {
      logic line_cond; // Receiver line condition pending.
      logic rx_avail; // Receive data available.
      logic rx_timeout; // Receive data time-out.
      logic thr_empty; // Transmit holding register empty.
      logic modem_change; // Modem line change.
   } uil_src_t;

   // Character format handed to the serial shifters.
   typedef struct packed {
      logic [3:0] word_bits; // Data bits per character, 5 to 8.
      uil_par_t parity; // Parity mode.
      logic [2:0] stop_halves; // Stop length in half bit times.
   } uil_fmt_t;

endpackage

// >>> src/uil_top.sv
// Interrupt identification and line format control of one UART channel, AXI4-Lite slave.
`timescale 1ns/100ps
module uil_top
   import uil_pkg::*;
(
   input wire logic clk_sys, // System clock, 20 MHz.
   input wire logic nrst, // Asynchronous active-low reset.
   // AXI4-Lite slave.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Channel side.
   input wire uil_src_t src, // Pending sources from the rest of the channel.
   input wire logic tx_serial, // Serial stream from the transmit shifter.
   output logic txd, // Serial line output.
   output uil_fmt_t fmt, // Character format.
   output logic fifo_en, // FIFO mode enable.
   output logic [7:0] fifo_ctl, // FIFO setup bits as programmed.
   output logic [15:0] divisor, // Baud divisor.
   output logic irq // Level interrupt.
);

   // ****************************************************************
   // Reset synchroniser.
   // ****************************************************************
   logic rst_s1_r; // First stage, read only by the second.
   logic rst_n_r; // Released reset used by all other logic.

   // Release is synchronised so that no flop leaves reset on a partial edge.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // ****************************************************************
   // Registers.
   // ****************************************************************
   logic [7:0] ident_r; // Interrupt identification.
   logic [7:0] lfc_r; // Line format control.
   logic [7:0] fsc_r; // FIFO setup control.
   logic [15:0] div_r; // Baud divisor latch.
   logic [UIL_NSRC-1:0] stat_r; // Sticky event bits.
   logic [UIL_NSRC-1:0] mask_r; // Event mask.
   logic [UIL_NSRC-1:0] src_prev_r; // Source levels one cycle ago.
   logic irq_r; // Registered interrupt.
   logic txd_r; // Registered serial output.
   uil_fmt_t fmt_r; // Registered format.

   // ****************************************************************
   // Identification priority encoder.
   // ****************************************************************
   logic [3:0] id_code; // Code of the winning source.
   logic [7:0] ident_nxt; // Next identification value.

   // The highest pending level always wins, so a lower source only shows once the
   // higher one has been serviced and its level dropped.
   assign id_code = src.line_cond ? UIL_ID_LINE :
                    src.rx_timeout ? UIL_ID_TMO :
                    src.rx_avail ? UIL_ID_RXAV :
                    src.thr_empty ? UIL_ID_THRE :
                    src.modem_change ? UIL_ID_MODEM :
                    UIL_ID_NONE;
   // Bits five and four are tied low; FIFO mode shows in the top pair.
   assign ident_nxt = {{2{fsc_r[UIL_FSC_EN]}}, 2'b00, id_code};

   // ****************************************************************
   // Format decode.
   // ****************************************************************
   uil_par_t par_mode; // Decoded parity.
   logic [2:0] stop_halves; // Decoded stop length.
   logic [3:0] word_bits; // Decoded character length.

   // Pattern 101 is taken as stick one; the other stick pattern is stick zero.
   assign par_mode = !lfc_r[UIL_LFC_PEN] ? UIL_PAR_NONE :
                     (!lfc_r[UIL_LFC_PEVEN] && lfc_r[UIL_LFC_PSTICK]) ? UIL_PAR_ONE :
                     !lfc_r[UIL_LFC_PEVEN] ? UIL_PAR_ODD :
                     !lfc_r[UIL_LFC_PSTICK] ? UIL_PAR_EVEN : UIL_PAR_ZERO;
   assign word_bits = 4'h5 + {2'b00, lfc_r[1:0]};
   assign stop_halves = !lfc_r[UIL_LFC_STOP] ? 3'h2 :
                        (lfc_r[1:0] == 2'b00) ? 3'h3 : 3'h4;

   // ****************************************************************
   // AXI4-Lite handshakes.
   // ****************************************************************
   logic awready_r; // Write address slot free.
   logic wready_r; // Write data slot free.
   logic bvalid_r; // Write answer pending.
   logic [1:0] bresp_r; // Write answer code.
   logic arready_r; // Read slot free.
   logic rvalid_r; // Read answer pending.
   logic [1:0] rresp_r; // Read answer code.
   logic [31:0] rdata_r; // Read data.
   logic [7:0] awaddr_r; // Captured write address.
   logic [31:0] wdata_r; // Captured write data.
   logic [3:0] wstrb_r; // Captured byte enables.
   logic aw_have_r; // Address captured.
   logic w_have_r; // Data captured.

   logic aw_hs; // Address handshake this cycle.
   logic w_hs; // Data handshake this cycle.
   logic ar_hs; // Read handshake this cycle.
   logic wr_go; // Write executes this cycle.
   logic wr_ident; // Write hits identification.
   logic wr_lfc; // Write hits line format.
   logic wr_fsc; // Write hits FIFO setup.
   logic wr_div; // Write hits divisor.
   logic wr_stat; // Write hits status.
   logic wr_mask; // Write hits mask.
   logic wr_hit; // Write address mapped.
   logic div_open; // Divisor access enabled.
   logic [31:0] rd_mux; // Read data selection.
   logic rd_hit; // Read address mapped.

   assign aw_hs = s_axi_awvalid && awready_r;
   assign w_hs = s_axi_wvalid && wready_r;
   assign ar_hs = s_axi_arvalid && arready_r;
   assign wr_go = aw_have_r && w_have_r && !bvalid_r;
   assign div_open = lfc_r[UIL_LFC_DLAB];
   assign wr_ident = wr_go && (awaddr_r == UIL_OFS_IDENT);
   assign wr_lfc = wr_go && (awaddr_r == UIL_OFS_LFC) && wstrb_r[0];
   assign wr_fsc = wr_go && (awaddr_r == UIL_OFS_FSC) && wstrb_r[0];
   assign wr_div = wr_go && (awaddr_r == UIL_OFS_DIV) && div_open;
   assign wr_stat = wr_go && (awaddr_r == UIL_OFS_STAT) && wstrb_r[0];
   assign wr_mask = wr_go && (awaddr_r == UIL_OFS_MASK) && wstrb_r[0];
   assign wr_hit = (awaddr_r == UIL_OFS_IDENT) || (awaddr_r == UIL_OFS_LFC) ||
                   (awaddr_r == UIL_OFS_FSC) || (awaddr_r == UIL_OFS_DIV) ||
                   (awaddr_r == UIL_OFS_STAT) || (awaddr_r == UIL_OFS_MASK);

   // A closed divisor reads as zero so software cannot mistake it for live data.
   assign rd_mux = (s_axi_araddr == UIL_OFS_IDENT) ? {24'h000000, ident_r} :
                   (s_axi_araddr == UIL_OFS_LFC) ? {24'h000000, lfc_r} :
                   (s_axi_araddr == UIL_OFS_FSC) ? {24'h000000, fsc_r} :
                   (s_axi_araddr == UIL_OFS_DIV) ? {16'h0000, div_open ? div_r : 16'h0000} :
                   (s_axi_araddr == UIL_OFS_STAT) ? {27'h0000000, stat_r} :
                   (s_axi_araddr == UIL_OFS_MASK) ? {27'h0000000, mask_r} : 32'h00000000;
   assign rd_hit = (s_axi_araddr == UIL_OFS_IDENT) || (s_axi_araddr == UIL_OFS_LFC) ||
                   (s_axi_araddr == UIL_OFS_FSC) || (s_axi_araddr == UIL_OFS_DIV) ||
                   (s_axi_araddr == UIL_OFS_STAT) || (s_axi_araddr == UIL_OFS_MASK);

   // Write channel: address and data are caught in either order, the write happens
   // once both are held, and both slots reopen when the answer is taken.
   always_ff @(posedge clk_sys or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= UIL_RESP_OKAY;
      end
      else
      begin
         if (aw_hs)
         begin
            awaddr_r <= s_axi_awaddr;
            aw_have_r <= 1'b1;
            awready_r <= 1'b0;
         end
         else if (!aw_have_r && !bvalid_r)
         begin
            awready_r <= 1'b1;
         end
         if (w_hs)
         begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            w_have_r <= 1'b1;
            wready_r <= 1'b0;
         end
         else if (!w_have_r && !bvalid_r)
         begin
            wready_r <= 1'b1;
         end
         if (wr_go)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? UIL_RESP_OKAY : UIL_RESP_SLVERR;
         end
         else if (bvalid_r && s_axi_bready)
         begin
            bvalid_r <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
         end
      end
   end

   // Read channel: one cycle from address handshake to data.
   always_ff @(posedge clk_sys or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= UIL_RESP_OKAY;
      end
      else if (ar_hs)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= rd_hit ? UIL_RESP_OKAY : UIL_RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready)
      begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
      else if (!rvalid_r)
      begin
         arready_r <= 1'b1;
      end
   end

   // ****************************************************************
   // Control registers.
   // ****************************************************************
   // A write to the identification offset is answered but stores nothing.
   always_ff @(posedge clk_sys or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         lfc_r <= UIL_RST_LFC;
         fsc_r <= UIL_RST_FSC;
         div_r <= UIL_RST_DIV;
         mask_r <= '0;
      end
      else
      begin
         if (wr_lfc)
         begin
            lfc_r <= wdata_r[7:0];
         end
         // Setup bits other than the enable only land when enable is written high.
         if (wr_fsc)
         begin
            fsc_r[UIL_FSC_EN] <= wdata_r[UIL_FSC_EN];
            if (wdata_r[UIL_FSC_EN])
            begin
               fsc_r[7:1] <= wdata_r[7:1];
            end
         end
         if (wr_div)
         begin
            if (wstrb_r[0])
            begin
               div_r[7:0] <= wdata_r[7:0];
            end
            if (wstrb_r[1])
            begin
               div_r[15:8] <= wdata_r[15:8];
            end
         end
         if (wr_mask)
         begin
            mask_r <= wdata_r[UIL_NSRC-1:0];
         end
      end
   end

   // ****************************************************************
   // Identification, events and outputs.
   // ****************************************************************
   logic [UIL_NSRC-1:0] src_vec; // Sources as a plain vector.
   logic [UIL_NSRC-1:0] src_rise; // Sources that just became pending.
   logic [UIL_NSRC-1:0] stat_nxt; // Next status.

   assign src_vec = src;
   assign src_rise = src_vec & ~src_prev_r;
   // A new event wins over a clear in the same cycle, so none is lost.
   assign stat_nxt = (stat_r & ~(wr_stat ? wdata_r[UIL_NSRC-1:0] : '0)) | src_rise;

   // The identification is refreshed every cycle, so a read sees the source that was on top
   // one cycle before its address handshake; sources are same-clock logic and need no synchroniser.
   always_ff @(posedge clk_sys or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         ident_r <= UIL_RST_IDENT;
         src_prev_r <= '0;
         stat_r <= '0;
         irq_r <= 1'b0;
         txd_r <= 1'b1;
         fmt_r <= {4'h5, UIL_PAR_NONE, 3'h2};
      end
      else
      begin
         ident_r <= ident_nxt;
         src_prev_r <= src_vec;
         stat_r <= stat_nxt;
         irq_r <= |(stat_nxt & mask_r);
         txd_r <= lfc_r[UIL_LFC_BRK] ? 1'b0 : tx_serial;
         fmt_r <= {word_bits, par_mode, stop_halves};
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign txd = txd_r;
   assign fmt = fmt_r;
   assign fifo_en = fsc_r[UIL_FSC_EN];
   assign fifo_ctl = fsc_r;
   assign divisor = div_r;
   assign irq = irq_r;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n_r);

   a_id_line: assert property (src.line_cond |=> ident_r[3:0] == 4'h6)
      else $error("line condition code wrong");
   a_id_timeout: assert property (!src.line_cond && src.rx_timeout |=> ident_r[3:0] == 4'hC)
      else $error("time-out code wrong");
   a_id_rxavail: assert property (src == 5'b01000 |=> ident_r[3:0] == 4'h4)
      else $error("data available code wrong");
   a_id_thremp: assert property (src == 5'b00010 |=> ident_r[3:0] == 4'h2)
      else $error("holding empty code wrong");
   a_id_modem: assert property (src == 5'b00001 |=> ident_r[3:0] == 4'h0)
      else $error("modem change code wrong");
   a_id_idle: assert property ((src == 5'b00000) |=> ident_r[0] && ident_r[5:4] == 2'b00)
      else $error("idle identification wrong");
   a_id_service: assert property (src.line_cond ##1 !src.line_cond && src.thr_empty
      && !src.rx_avail && !src.rx_timeout |=> ident_r[3:0] == 4'h2)
      else $error("lower source not shown after service");
   a_id_fifo: assert property (1'b1 |=> ident_r[7:6] == {2{$past(fsc_r[0])}})
      else $error("fifo bits in identification wrong");
   a_tx_break: assert property (lfc_r[6] |=> !txd_r)
      else $error("break not held low");
   a_div_closed: assert property (wr_go && !lfc_r[7] |=> $stable(div_r))
      else $error("divisor written while closed");
   a_fsc_gate: assert property (wr_fsc && !wdata_r[0] |=> fsc_r[7:1] == $past(fsc_r[7:1]))
      else $error("fifo setup bits written without enable");
   a_fmt_stop: assert property (lfc_r[2] && lfc_r[1:0] == 2'b00 |=> fmt_r.stop_halves == 3'h3)
      else $error("stop length for five bits wrong");
   a_fmt_stick: assert property (lfc_r[5:3] == 3'b101 |=> fmt_r.parity == UIL_PAR_ONE)
      else $error("stick one parity wrong");
   a_fmt_word: assert property (1'b1 |=> fmt_r.word_bits == 4'h5 + {2'b00, $past(lfc_r[1:0])})
      else $error("word length wrong");

endmodule

// >>> dv/uil_chan_model.sv
// Behavioural model of the channel logic that feeds pending sources and the serial stream.
`timescale 1ns/100ps
module uil_chan_model
   import uil_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire uil_src_t want,
   output uil_src_t src,
   output logic tx_serial
);
   // Pattern register; a changing stream shows whether txd really follows it.
   logic [7:0] pat_r;

   // ****************************************************************
   // Source levels stay up until the bench services them.
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         src <= '0;
         pat_r <= 8'hA5;
      end
      else
      begin
         src <= want;
         pat_r <= {pat_r[6:0], pat_r[7] ^ pat_r[5]};
      end
   end
   assign tx_serial = pat_r[0];
endmodule

// >>> dv/tb_top.sv
// Self-checking testbench of the identification and line format block.
`timescale 1ns/100ps
module tb_top
   import uil_pkg::*;
;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, txd, tx_serial, fifo_en, irq, tx_prev;
   logic [1:0] bresp, rresp, brsp, rrsp;
   logic [31:0] rdata, rdat, rv;
   logic [7:0] fifo_ctl, l;
   logic [15:0] divisor;
   uil_src_t want = '0;
   uil_src_t src;
   uil_fmt_t fmt;
   int errors = 0;
   int checked = 0;
   logic [31:0] seed = 32'h23; // Fixed seed keeps every run alike.

   always #25 clk_sys = ~clk_sys;
   // Serial stream one cycle back, which txd must show outside a break.
   always @(posedge clk_sys) tx_prev <= tx_serial;

   uil_top uil_top_i (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .src(src),
      .tx_serial(tx_serial), .txd(txd), .fmt(fmt), .fifo_en(fifo_en), .fifo_ctl(fifo_ctl),
      .divisor(divisor), .irq(irq));
   uil_chan_model uil_chan_model_i (.clk_sys(clk_sys), .nrst(nrst), .want(want), .src(src),
      .tx_serial(tx_serial));

   // Xorshift generator for the random stimulus.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected identification code; time-out ranks above plain data.
   function automatic logic [3:0] id_code(input uil_src_t s);
      if (s.line_cond)
         return UIL_ID_LINE;
      if (s.rx_timeout)
         return UIL_ID_TMO;
      if (s.rx_avail)
         return UIL_ID_RXAV;
      if (s.thr_empty)
         return UIL_ID_THRE;
      if (s.modem_change)
         return UIL_ID_MODEM;
      return UIL_ID_NONE;
   endfunction

   // Expected character format for a line format value.
   function automatic uil_fmt_t fmt_of(input logic [7:0] v);
      uil_fmt_t f;
      f.word_bits = 4'h5 + {2'b00, v[1:0]};
      f.stop_halves = !v[2] ? 3'h2 : (v[1:0] == 2'b00 ? 3'h3 : 3'h4);
      case (v[5:3])
         3'b001: f.parity = UIL_PAR_ODD;
         3'b011: f.parity = UIL_PAR_EVEN;
         3'b101: f.parity = UIL_PAR_ONE;
         3'b111: f.parity = UIL_PAR_ZERO;
         default: f.parity = UIL_PAR_NONE;
      endcase
      return f;
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Write cycle; address and data offered together, each dropped once taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge clk_sys);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      brsp = bresp;
      bready <= 1'b0;
   endtask

   // Read cycle; the answer is taken at the edge where rvalid is seen.
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge clk_sys);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      rdat = rdata;
      rrsp = rresp;
      rready <= 1'b0;
   endtask

   task automatic report_and_stop();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial
   begin
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd(UIL_OFS_IDENT);
      chk("ident_rst", rdat, 32'(UIL_RST_IDENT));
      // Each source alone first, then random mixtures.
      for (int i = 0; i < 45; i++)
      begin
         rv = rnd();
         want <= (i < 5) ? uil_src_t'(5'h01 << i) : uil_src_t'(rv[4:0]);
         repeat (3) @(posedge clk_sys);
         rd(UIL_OFS_IDENT);
         chk("ident", rdat, {28'h0, id_code(want)});
      end
      // Lower source shows only once the top one is serviced.
      want <= 5'h18;
      repeat (3) @(posedge clk_sys);
      rd(UIL_OFS_IDENT);
      chk("ident_top", rdat, 32'h06);
      want <= 5'h08;
      repeat (3) @(posedge clk_sys);
      rd(UIL_OFS_IDENT);
      chk("ident_next", rdat, 32'h04);
      // Line condition serviced with only the holding register left pending.
      want <= 5'h12;
      repeat (3) @(posedge clk_sys);
      want <= 5'h02;
      repeat (3) @(posedge clk_sys);
      rd(UIL_OFS_IDENT);
      chk("ident_lower", rdat, 32'h02);
      want <= 5'h08;
      repeat (3) @(posedge clk_sys);
      wr(UIL_OFS_FSC, 32'hC1);
      chk("fifo_on", 32'({fifo_en, fifo_ctl}), 32'h1C1);
      rd(UIL_OFS_IDENT);
      chk("ident_fifo", rdat, 32'hC4);
      wr(UIL_OFS_FSC, 32'hFE);
      chk("fifo_ctl", 32'(fifo_ctl), 32'hC0);
      chk("fifo_en", 32'(fifo_en), 32'h0);
      wr(UIL_OFS_IDENT, 32'hFF);
      chk("ident_wr_resp", 32'(brsp), 32'(UIL_RESP_OKAY));
      rd(UIL_OFS_IDENT);
      chk("ident_wr", rdat, 32'h04);
      // All parity patterns first, then random formats.
      for (int i = 0; i < 40; i++)
      begin
         rv = rnd();
         l = (i < 8) ? {2'b00, i[2:0], 1'b1, i[1:0]} : rv[7:0];
         wr(UIL_OFS_LFC, {24'h0, l});
         @(posedge clk_sys);
         chk("fmt", 32'(fmt), 32'(fmt_of(l)));
         if (l[6])
            chk("txd_break", 32'(txd), 32'h0);
         else
            chk("txd_follow", 32'(txd), 32'(tx_prev));
         rd(UIL_OFS_LFC);
         chk("lfc", rdat, {24'h0, l});
      end
      wr(UIL_OFS_LFC, 32'h0);
      wr(UIL_OFS_DIV, 32'h1234);
      rd(UIL_OFS_DIV);
      chk("div_closed", rdat, 32'h0);
      chk("div_keep", 32'(divisor), 32'(UIL_RST_DIV));
      wr(UIL_OFS_LFC, 32'h80);
      wr(UIL_OFS_DIV, 32'h1234);
      rd(UIL_OFS_DIV);
      chk("div_open", rdat, 32'h1234);
      rd(8'h40);
      chk("unmapped", {rdat[29:0], rrsp}, 32'h2);
      wr(8'h40, 32'h0);
      chk("unmapped_wr", 32'(brsp), 32'(UIL_RESP_SLVERR));
      // Interrupt: sticky status, mask and clear by writing one.
      want <= 5'h00;
      wr(UIL_OFS_STAT, 32'h1F);
      wr(UIL_OFS_MASK, 32'h10);
      want <= 5'h11;
      repeat (4) @(posedge clk_sys);
      chk("irq_set", 32'(irq), 32'h1);
      rd(UIL_OFS_STAT);
      chk("status", rdat, 32'h11);
      wr(UIL_OFS_STAT, 32'h10);
      @(posedge clk_sys);
      chk("irq_clr", 32'(irq), 32'h0);
      report_and_stop();
   end

   // Watchdog at 40000 cycles, far beyond the under one thousand cycles the sequence needs.
   initial
   begin
      #2000000;
      errors++;
      report_and_stop();
   end
endmodule
